// [rtl/flpb_top.v]
// FLP burst timing with indirect MMD interval registers behind the management port
//
// Contract
// - Burst-to-burst spacing held within 8 to 24 ms, 16 ms nominal; a restart starts the next burst without waiting out the interval.
// - Data pulse sits 64 us after its clock pulse.
// - Clock pulses within a burst are 128 us apart.
// - Each burst carries 17 to 33 pulses, clock and data together.
// - Interval resets to 8 ms until software reprograms it.
// - Data write in address mode picks the target MMD register number.
// - Data write in data mode stores value into selected MMD register.
`timescale 1ns/1ps
`include "flpb_map.vh"

module flpb_top #(
	parameter UNIT_CYC = `FLPB_INTV_UNIT_NS / `FLPB_CLK_PERIOD_NS,
	parameter MIN_CYC  = `FLPB_BTB_MIN_NS / `FLPB_CLK_PERIOD_NS,
	parameter MAX_CYC  = `FLPB_BTB_MAX_NS / `FLPB_CLK_PERIOD_NS
) (
	input  wire        clk_i,
	input  wire        resetn_i,
	input  wire        an_enable_i,
	input  wire        an_restart_i,
	input  wire [15:0] code_word_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	input  wire [4:0]  reg_addr_i,
	input  wire [15:0] reg_wdata_i,
	output reg  [15:0] reg_rdata_o,
	output reg         flp_pulse_o,
	output reg         burst_active_o,
	output reg  [31:0] burst_interval_cyc_o
);

	// ----------------------------------------
	// Indirect access registers
	// ----------------------------------------
	reg  [15:0] ctrl_r;
	reg  [15:0] mmd_regsel_r;
	reg  [15:0] intv_hi_r;
	reg  [15:0] intv_lo_r;
	reg  [31:0] intv_cyc_nxt;
	reg  [31:0] gap_cnt_r;
	reg         restart_r;
	reg  [15:0] mmd_rdata;
	wire [1:0]  func     = ctrl_r[`FLPB_FUNC_MSB:`FLPB_FUNC_LSB];
	wire        dev_hit  = ctrl_r[`FLPB_DEVAD_MSB:0] == `FLPB_INTV_DEVAD;
	wire        wr_ctrl  = reg_wr_i && (reg_addr_i == `FLPB_ADDR_CTRL);
	wire        wr_data  = reg_wr_i && (reg_addr_i == `FLPB_ADDR_DATA);
	wire        data_mode = (func == `FLPB_FUNC_DATA) && dev_hit;
	wire        gen_busy;
	wire        gen_pulse;
	wire        start_burst;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_r       <= `FLPB_CTRL_RST;
			mmd_regsel_r <= `FLPB_DATA_RST;
			intv_hi_r    <= `FLPB_INTV_HI_RST;
			intv_lo_r    <= `FLPB_INTV_LO_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= reg_wdata_i;
			end
			if (wr_data && func == `FLPB_FUNC_ADDR) begin
				mmd_regsel_r <= reg_wdata_i;
			end
			if (wr_data && data_mode) begin
				if (mmd_regsel_r == `FLPB_INTV_REG_HI) begin
					intv_hi_r <= reg_wdata_i;
				end
				if (mmd_regsel_r == `FLPB_INTV_REG_LO) begin
					intv_lo_r <= reg_wdata_i;
				end
			end
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always @* begin
		mmd_rdata = 16'h0000;
		if (!data_mode) begin
			mmd_rdata = mmd_regsel_r;
		end else if (mmd_regsel_r == `FLPB_INTV_REG_HI) begin
			mmd_rdata = intv_hi_r;
		end else if (mmd_regsel_r == `FLPB_INTV_REG_LO) begin
			mmd_rdata = intv_lo_r;
		end
	end

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`FLPB_ADDR_CTRL: begin
					reg_rdata_o <= ctrl_r;
				end
				`FLPB_ADDR_DATA: begin
					reg_rdata_o <= mmd_rdata;
				end
				default: begin
					reg_rdata_o <= 16'h0000;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Burst-to-burst interval
	// ----------------------------------------
	// Interval value counts 40 ns units; clamped so a bad value cannot leave the legal window
	always @* begin
		intv_cyc_nxt = {intv_hi_r, intv_lo_r} * UNIT_CYC[31:0];
		if (intv_cyc_nxt < MIN_CYC[31:0]) begin
			intv_cyc_nxt = MIN_CYC[31:0];
		end else if (intv_cyc_nxt > MAX_CYC[31:0]) begin
			intv_cyc_nxt = MAX_CYC[31:0];
		end
	end

	// Restart starts a burst as soon as the generator is idle, without waiting out the interval
	assign start_burst = an_enable_i && !gen_busy &&
		(restart_r || gap_cnt_r >= burst_interval_cyc_o - 32'h1);

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			gap_cnt_r            <= 32'h0;
			restart_r            <= 1'b0;
			burst_interval_cyc_o <= 32'h0;
			flp_pulse_o          <= 1'b0;
			burst_active_o       <= 1'b0;
		end else begin
			burst_interval_cyc_o <= intv_cyc_nxt;
			flp_pulse_o          <= gen_pulse;
			burst_active_o       <= gen_busy;
			restart_r            <= an_restart_i || (restart_r && !start_burst);
			if (start_burst || !an_enable_i) begin
				gap_cnt_r <= 32'h0;
			end else begin
				gap_cnt_r <= gap_cnt_r + 32'h1;
			end
		end
	end

	flpb_pulse_gen u_gen (
		.clk_i       (clk_i),
		.resetn_i    (resetn_i),
		.start_i     (start_burst),
		.code_word_i (code_word_i),
		.pulse_o     (gen_pulse),
		.busy_o      (gen_busy)
	);

endmodule

// [shared/flpb_map.vh]
// Register offsets, field positions, reset values and timing constants for the FLP burst block
`ifndef FLPB_MAP_VH
`define FLPB_MAP_VH

// ----------------------------------------
// Register offsets (5-bit management address)
// ----------------------------------------
`define FLPB_ADDR_CTRL      5'h0d
`define FLPB_ADDR_DATA      5'h0e

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define FLPB_FUNC_MSB       15
`define FLPB_FUNC_LSB       14
`define FLPB_FUNC_ADDR      2'h0
`define FLPB_FUNC_DATA      2'h1
`define FLPB_DEVAD_MSB      4
`define FLPB_INTV_DEVAD     5'h00
`define FLPB_INTV_REG_HI    16'h0004
`define FLPB_INTV_REG_LO    16'h0003

// ----------------------------------------
// Reset values: 8 ms burst interval default
// ----------------------------------------
`define FLPB_CTRL_RST       16'h0000
`define FLPB_DATA_RST       16'h0000
`define FLPB_INTV_HI_RST    16'h0003
`define FLPB_INTV_LO_RST    16'h0d40

// ----------------------------------------
// Timing, in ns, and clock rate
// ----------------------------------------
`define FLPB_CLK_PERIOD_NS  20
`define FLPB_CTD_NS         64000
`define FLPB_CTC_NS         128000
`define FLPB_PW_NS          100
`define FLPB_BTB_MIN_NS     8000000
`define FLPB_BTB_MAX_NS     24000000
`define FLPB_INTV_UNIT_NS   40
`define FLPB_PULSES         33

`endif

// [rtl/flpb_pulse_gen.v]
// Single FLP burst sequencer: alternate clock and data pulse slots
`timescale 1ns/1ps
`include "flpb_map.vh"

module flpb_pulse_gen #(
	parameter CTD_CYC = `FLPB_CTD_NS / `FLPB_CLK_PERIOD_NS,
	parameter PW_CYC  = `FLPB_PW_NS / `FLPB_CLK_PERIOD_NS,
	parameter PULSES  = `FLPB_PULSES
) (
	input  wire        clk_i,
	input  wire        resetn_i,
	input  wire        start_i,
	input  wire [15:0] code_word_i,
	output reg         pulse_o,
	output reg         busy_o
);

	reg [11:0] slot_cnt_r;
	reg [5:0]  idx_r;

	// ----------------------------------------
	// Slot timer
	// ----------------------------------------
	// Even slots are clock pulses; odd slots are data pulses, sent only for a one bit
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			slot_cnt_r <= 12'h000;
			idx_r      <= 6'h00;
			busy_o     <= 1'b0;
			pulse_o    <= 1'b0;
		end else begin
			if (!busy_o) begin
				pulse_o <= 1'b0;
				if (start_i) begin
					busy_o     <= 1'b1;
					slot_cnt_r <= 12'h000;
					idx_r      <= 6'h00;
				end
			end else begin
				pulse_o <= (slot_cnt_r < PW_CYC[11:0]) &&
					(!idx_r[0] || code_word_i[idx_r[4:1]]);
				if (slot_cnt_r == CTD_CYC[11:0] - 12'h001) begin
					slot_cnt_r <= 12'h000;
					if (idx_r == PULSES[5:0] - 6'h01) begin
						busy_o <= 1'b0;
					end else begin
						idx_r <= idx_r + 6'h01;
					end
				end else begin
					slot_cnt_r <= slot_cnt_r + 12'h001;
				end
			end
		end
	end

endmodule

// [test/flpb_chk.sv]
// Checker for the FLP burst block ports
`timescale 1ns/1ps
module flpb_chk #(
	parameter MIN_CYC = 32'h61a80,
	parameter MAX_CYC = 32'h124f80
) (
	input logic        clk_i,
	input logic        resetn_i,
	input logic        reg_wr_i,
	input logic        reg_rd_i,
	input logic [4:0]  reg_addr_i,
	input logic [15:0] reg_wdata_i,
	input logic [15:0] reg_rdata_o,
	input logic        flp_pulse_o,
	input logic        burst_active_o,
	input logic [31:0] burst_interval_cyc_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	logic [15:0] gap_r, sel_r;
	logic [5:0]  cnt_r;
	logic [1:0]  fn_r;
	logic        seen_r, p_r;
	wire wr_d = reg_wr_i && reg_addr_i == 5'h0e;
	wire rise = flp_pulse_o && !p_r;
	// Gap saturates so a long idle never wraps into a false pass
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			{gap_r, sel_r, cnt_r, fn_r, seen_r, p_r} <= '0;
		end else begin
			p_r <= flp_pulse_o;
			gap_r <= rise ? 16'h1 : gap_r + {15'h0, gap_r != 16'hffff};
			cnt_r <= burst_active_o ? cnt_r + {5'h0, rise} : 6'h0;
			seen_r <= burst_active_o && (seen_r || rise);
			if (reg_wr_i && reg_addr_i == 5'h0d)
				fn_r <= reg_wdata_i[15:14];
			if (wr_d && fn_r == 2'h0)
				sel_r <= reg_wdata_i;
		end
	end
	a_intv_range: assert property ($past(resetn_i, 3) |-> burst_interval_cyc_o >= MIN_CYC
		&& burst_interval_cyc_o <= MAX_CYC) else $error("interval out of range");
	a_reset_intv: assert property ($rose(resetn_i) |=> burst_interval_cyc_o == 32'h61a80)
		else $error("reset interval wrong");
	a_pulse_gap: assert property (rise && seen_r |-> gap_r == 16'hc80 || gap_r == 16'h1900)
		else $error("pulse spacing wrong");
	a_pulse_width: assert property (rise |-> flp_pulse_o [*5] ##1 !flp_pulse_o)
		else $error("pulse width wrong");
	a_burst_size: assert property ($fell(burst_active_o) |-> cnt_r >= 6'd17 && cnt_r <= 6'd33)
		else $error("pulse count wrong");
	a_pulse_inside: assert property (flp_pulse_o |-> burst_active_o)
		else $error("pulse outside burst");
	a_intv_cause: assert property ($changed(burst_interval_cyc_o) && $past(resetn_i, 3) |->
		$past(wr_d) || $past(wr_d, 2) || $past(wr_d, 3)) else $error("interval moved alone");
	a_sel_echo: assert property (reg_rd_i && reg_addr_i == 5'h0e && fn_r == 2'h0 |=>
		reg_rdata_o == sel_r) else $error("selected register not echoed");
	c_burst: cover property ($fell(burst_active_o));
	c_gap: cover property (rise && seen_r);
	c_sel: cover property (reg_rd_i && reg_addr_i == 5'h0e && fn_r == 2'h0);
endmodule
bind flpb_top flpb_chk #(.MIN_CYC(MIN_CYC), .MAX_CYC(MAX_CYC)) i_flpb_chk (.*);

// [test/flpb_partner.sv]
// Link partner model: logs the cycle of every received pulse rise
`timescale 1ns/1ps
module flpb_partner (
	input logic clk_i,
	input logic line_i
);
	int   cyc = 0;
	int   rise_q[$];
	logic prev_r = 1'h0;
	// Receive only: the partner never drives this line
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		prev_r <= line_i;
		if (line_i && !prev_r)
			rise_q.push_back(cyc);
	end
endmodule

// [test/flpb_top_tb.sv]
// Testbench for the FLP burst block
`timescale 1ns/1ps
module flpb_top_tb;
	logic        clk_i = 1'h0, resetn_i = 1'h0, an_enable_i = 1'h0, an_restart_i = 1'h0;
	logic        reg_wr_i = 1'h0, reg_rd_i = 1'h0, flp_pulse_o, burst_active_o;
	logic [4:0]  reg_addr_i = 5'h0;
	logic [15:0] code_word_i = 16'h0, reg_wdata_i = 16'h0, reg_rdata_o;
	logic [31:0] burst_interval_cyc_o;
	int          err_total = 0, cmp_count = 0, n, q[$];
	// Floor shrunk so a short interval is legal in simulation
	flpb_top #(.MIN_CYC(32'h3e8)) i_flpb_top (.*);
	flpb_partner i_flpb_partner (.clk_i(clk_i), .line_i(flp_pulse_o));
	initial forever #10 clk_i = ~clk_i;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		reg_wr_i = 1'h1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge clk_i);
		reg_wr_i = 1'h0;
		@(negedge clk_i);
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		reg_rd_i = 1'h1;
		reg_addr_i = a;
		@(negedge clk_i);
		reg_rd_i = 1'h0;
		@(negedge clk_i);
		chk({16'h0, reg_rdata_o}, {16'h0, e});
	endtask
	task automatic setc(input logic [15:0] r, input logic [15:0] v, input logic [31:0] e);
		wr(5'h0d, 16'h0);
		wr(5'h0e, r);
		wr(5'h0d, 16'h4000);
		wr(5'h0e, v);
		repeat (4) @(negedge clk_i);
		chk(burst_interval_cyc_o, e);
	endtask
	task automatic t_regs;
		@(negedge clk_i);
		chk(burst_interval_cyc_o, 32'h61a80);
		repeat (5000) @(negedge clk_i);
		rd(5'h0d, 16'h0);
		setc(16'h4, 16'h6, 32'hc1a80);
		setc(16'h3, 16'h1a80, 32'hc3500);
		rd(5'h0d, 16'h4000);
		rd(5'h0e, 16'h1a80);
		wr(5'h0d, 16'h0);
		rd(5'h0e, 16'h3);
		wr(5'h0d, 16'h8000);
		wr(5'h0e, 16'h1234);
		wr(5'h0d, 16'h4001);
		wr(5'h0e, 16'h5555);
		wr(5'h1f, 16'hffff);
		rd(5'h1f, 16'h0);
		wr(5'h0d, 16'h4000);
		rd(5'h0e, 16'h1a80);
		chk(burst_interval_cyc_o, 32'hc3500);
		$display("register test done");
	endtask
	task automatic t_clamp;
		setc(16'h3, 16'h64, 32'hc00c8);
		setc(16'h4, 16'h0, 32'h3e8);
		setc(16'h4, 16'ha, 32'h124f80);
		setc(16'h4, 16'h0, 32'h3e8);
		setc(16'h3, 16'h7d0, 32'hfa0);
		$display("clamp test done");
	endtask
	task automatic t_burst;
		code_word_i = 16'h3;
		an_enable_i = 1'h1;
		an_restart_i = 1'h1;
		@(negedge clk_i);
		an_restart_i = 1'h0;
		for (n = 0; n < 120000 && burst_active_o !== 1'h1; n++)
			@(negedge clk_i);
		for (n = 0; n < 120000 && burst_active_o !== 1'h0; n++)
			@(negedge clk_i);
		an_enable_i = 1'h0;
		q = i_flpb_partner.rise_q;
		chk(q.size(), 19);
		chk(q[1] - q[0], 32'hc80);
		chk(q[2] - q[0], 32'h1900);
		chk(q[3] - q[2], 32'hc80);
		chk(q[18] - q[0], 32'h19000);
		$display("burst test done");
	endtask
	initial begin
		#3000000;
		err_total++;
		end_sim;
	end
	initial begin
		repeat (4) @(negedge clk_i);
		resetn_i = 1'h1;
		t_regs;
		t_clamp;
		t_burst;
		end_sim;
	end
endmodule
